// file: logic/dwsc_ctrl.v
// writeback memory-to-memory control, sync-lost detection and enhanced standby control
// assumes apb master on pclk; pipe and panel status inputs synchronous to pclk
//
// Local design decision: the APB interface to the registers.
`include "dwsc_map.vh"
`default_nettype none
module dwsc_ctrl #(
  parameter NPIPE = 3
) (
  // clock and reset
  input  wire              pclk,
  input  wire              presetn,
  input  wire              clk_en,
  // apb slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // writeback engine
  input  wire              wb_job_done,
  output reg               wb_enable,
  output reg               wb_mem_to_mem,
  // video pipes and panel
  input  wire              frame_start,
  input  wire              panel_active,
  output reg  [NPIPE-1:0]  pipe_enable,
  output reg  [NPIPE-1:0]  pipe_to_panel,
  output reg               frame_corrupt,
  // standby
  input  wire              smart_standby,
  input  wire              dma_thresh_ok,
  input  wire              standby_req,
  output reg               mstandby,
  output reg               underflow_risk,
  // interrupt
  output reg               irq
);
  reg  [31:0]             wb_attr_q;
  reg  [NPIPE-1:0]        vid_en_q;
  reg  [NPIPE-1:0]        route_q;
  reg  [`DWSC_IRQ_WIDTH-1:0] sts_q;
  reg  [`DWSC_IRQ_WIDTH-1:0] mask_q;
  reg                     stby_dis_q;
  reg                     wb_busy_q;
  reg                     resync_q;
  reg  [`DWSC_IRQ_WIDTH-1:0] evt_d;
  reg  [31:0]             rdata_d;
  reg                     err_d;
  wire                    acc;
  wire                    wr;
  wire                    rd;
  wire                    done_evt;
  wire                    retarget;
  wire [NPIPE-1:0]        new_route;
  integer                 n_en;
  integer                 i;

  assign acc       = psel & penable & pready;
  assign wr        = acc & pwrite;
  assign rd        = acc & ~pwrite;
  assign done_evt  = wb_busy_q & wb_job_done & wb_attr_q[`DWSC_BIT_M2M];
  assign new_route = pwdata[NPIPE-1:0];
  assign retarget  = wr && (paddr == `DWSC_OFF_PANEL_ROUTE);

  // read mux and decode
  always @* begin
    rdata_d = 32'h00000000;
    err_d   = 1'b0;
    case (paddr)
      `DWSC_OFF_WB_ATTR:     rdata_d = wb_attr_q;
      `DWSC_OFF_VID_ATTR:    rdata_d[NPIPE-1:0] = vid_en_q;
      `DWSC_OFF_PANEL_ROUTE: rdata_d[NPIPE-1:0] = route_q;
      `DWSC_OFF_IRQ_STATUS:  rdata_d[`DWSC_IRQ_WIDTH-1:0] = sts_q;
      `DWSC_OFF_IRQ_MASK:    rdata_d[`DWSC_IRQ_WIDTH-1:0] = mask_q;
      `DWSC_OFF_STANDBY_STS: rdata_d[1:0] = {underflow_risk, mstandby};
      `DWSC_OFF_STBY_ENH:    rdata_d[0] = stby_dis_q;
      default:               err_d = 1'b1;
    endcase
  end

  // event detection
  always @* begin
    n_en = 0;
    for (i = 0; i < NPIPE; i = i + 1)
      n_en = n_en + vid_en_q[i];
    evt_d = {`DWSC_IRQ_WIDTH{1'b0}};
    evt_d[`DWSC_IRQ_WB_DONE] = done_evt;
    // enabled pipe newly routed to a live panel outside frame start
    evt_d[`DWSC_IRQ_SYNC_LOST] = retarget && panel_active && !frame_start &&
                                 |(new_route & ~route_q & vid_en_q);
    evt_d[`DWSC_IRQ_UNDERFLOW] = !stby_dis_q && smart_standby && (n_en > 1);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_attr_q      <= 32'h00000000;
      vid_en_q       <= {NPIPE{1'b0}};
      route_q        <= {NPIPE{1'b0}};
      sts_q          <= {`DWSC_IRQ_WIDTH{1'b0}};
      mask_q         <= {`DWSC_IRQ_WIDTH{1'b0}};
      stby_dis_q     <= `DWSC_STBY_ENH_RESET;
      wb_busy_q      <= 1'b0;
      resync_q       <= 1'b0;
      prdata         <= 32'h00000000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      wb_enable      <= 1'b0;
      wb_mem_to_mem  <= 1'b0;
      pipe_enable    <= {NPIPE{1'b0}};
      pipe_to_panel  <= {NPIPE{1'b0}};
      frame_corrupt  <= 1'b0;
      mstandby       <= 1'b0;
      underflow_risk <= 1'b0;
      irq            <= 1'b0;
    end else if (clk_en) begin
      // one wait state: pready in second access cycle
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & err_d;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rdata_d;
      if (wr) begin
        case (paddr)
          `DWSC_OFF_WB_ATTR:     wb_attr_q <= pwdata;
          `DWSC_OFF_VID_ATTR:    vid_en_q <= pwdata[NPIPE-1:0];
          `DWSC_OFF_PANEL_ROUTE: route_q <= new_route;
          `DWSC_OFF_IRQ_MASK:    mask_q <= pwdata[`DWSC_IRQ_WIDTH-1:0];
          `DWSC_OFF_STBY_ENH:    stby_dis_q <= pwdata[0];
          default:               ;
        endcase
      end
      // writeback job tracking
      if (wr && paddr == `DWSC_OFF_WB_ATTR)
        wb_busy_q <= pwdata[`DWSC_BIT_ENABLE];
      else if (done_evt)
        wb_busy_q <= 1'b0;
      // auto-clear wins over a software write in the same cycle; pipe enable untouched
      if (done_evt)
        wb_attr_q[`DWSC_BIT_ENABLE] <= 1'b0;
      // pending frame corruption until next frame start
      if (evt_d[`DWSC_IRQ_SYNC_LOST])
        resync_q <= 1'b1;
      else if (frame_start)
        resync_q <= 1'b0;
      frame_corrupt <= (resync_q & ~frame_start) | evt_d[`DWSC_IRQ_SYNC_LOST];
      // sticky status, read clears, set wins
      if (rd && paddr == `DWSC_OFF_IRQ_STATUS)
        sts_q <= evt_d;
      else
        sts_q <= sts_q | evt_d;
      irq <= |((sts_q | evt_d) & mask_q);
      wb_enable      <= done_evt ? 1'b0 : wb_attr_q[`DWSC_BIT_ENABLE];
      wb_mem_to_mem  <= wb_attr_q[`DWSC_BIT_M2M];
      pipe_enable    <= vid_en_q;
      pipe_to_panel  <= route_q;
      // enhanced mode ignores dma threshold quality
      mstandby       <= standby_req & (dma_thresh_ok | ~stby_dis_q);
      underflow_risk <= evt_d[`DWSC_IRQ_UNDERFLOW];
    end
  end
endmodule
`default_nettype wire

// file: logic/dwsc_map.vh
// register offsets, field positions and reset values for the writeback/standby control block
// assumes a 32-bit apb slave with word-aligned byte addresses
`ifndef DWSC_MAP_VH
`define DWSC_MAP_VH
`define DWSC_OFF_WB_ATTR     12'h000
`define DWSC_OFF_VID_ATTR    12'h004
`define DWSC_OFF_PANEL_ROUTE 12'h008
`define DWSC_OFF_IRQ_STATUS  12'h00C
`define DWSC_OFF_IRQ_MASK    12'h010
`define DWSC_OFF_STANDBY_STS 12'h014
`define DWSC_OFF_STBY_ENH    12'h858
`define DWSC_STBY_ENH_PADDR  32'h58001858
`define DWSC_BIT_ENABLE      0
`define DWSC_BIT_M2M         19
`define DWSC_IRQ_WB_DONE     0
`define DWSC_IRQ_SYNC_LOST   1
`define DWSC_IRQ_UNDERFLOW   2
`define DWSC_IRQ_WIDTH       3
`define DWSC_STBY_ENH_RESET  1'b0
`endif

// file: sim/dwsc_ctrl_properties.sv
// checker: port relations of dwsc_ctrl
// assumes one pclk domain and async active-low presetn
`default_nettype none
module dwsc_chk #(parameter NPIPE = 3) (
  // watched ports
  input wire logic pclk, presetn, clk_en, psel, penable, pready, pslverr, wb_job_done, wb_enable,
  input wire logic wb_mem_to_mem, frame_start, frame_corrupt, standby_req, dma_thresh_ok, mstandby,
  input wire logic smart_standby, underflow_risk,
  input wire logic [NPIPE-1:0] pipe_enable);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && !penable && clk_en ##1 clk_en |-> ##1 pready) else $error("late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_done_clear: assert property (wb_enable && wb_mem_to_mem && wb_job_done && clk_en && !psel
    |=> !wb_enable && $stable(pipe_enable)) else $error("no auto clear");
  a_m2m_only: assert property (wb_enable && !wb_mem_to_mem && !psel && !$past(psel) |=> wb_enable)
    else $error("cleared");
  a_corrupt_hold: assert property (frame_corrupt && !frame_start |=> frame_corrupt) else $error("drop");
  a_corrupt_end: assert property (frame_corrupt && frame_start && clk_en |=> !frame_corrupt) else $error("stuck");
  a_standby_ok: assert property ((standby_req && dma_thresh_ok && clk_en)[*3] |-> mstandby) else $error("no stby");
  a_no_risk: assert property ((!smart_standby)[*2] |-> !underflow_risk) else $error("false risk");
endmodule
bind dwsc_ctrl dwsc_chk #(.NPIPE(NPIPE)) u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pready, .pslverr,
  .wb_job_done, .wb_enable, .wb_mem_to_mem, .frame_start, .frame_corrupt, .standby_req, .dma_thresh_ok,
  .mstandby, .smart_standby, .underflow_risk, .pipe_enable);
`default_nettype wire

// file: sim/dwsc_partner.sv
// model of writeback engine, pipe frame timing and active panel
// assumes pclk domain; a job ends job_len+1 cycles after enable
`default_nettype none
module dwsc_partner (
  input wire logic pclk, presetn, wb_enable, hold_frame,
  input wire logic [7:0] job_len,
  output logic wb_job_done, frame_start, panel_active);
  timeunit 1ns; timeprecision 1ps;
  logic [7:0] jc;
  logic [5:0] fc;
  assign panel_active = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {jc, fc, wb_job_done, frame_start} <= '0;
    end else begin
      jc <= wb_enable ? jc + 8'h01 : 8'h00;
      wb_job_done <= wb_enable && jc == job_len;
      fc <= fc + 6'h01;
      frame_start <= !hold_frame && fc == 6'h3F;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_display_writeback_standby_ctrl.sv
// bench for dwsc_ctrl: apb master, partner model, standby inputs
// assumes byte offsets as chosen for the block
`default_nettype none
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_display_writeback_standby_ctrl;
  timeunit 1ns; timeprecision 1ps;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, wb_job_done, wb_enable, wb_mem_to_mem, irq;
  logic frame_start, panel_active, frame_corrupt, smart_standby, dma_thresh_ok, standby_req, mstandby, risk, hf, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pipe_enable, ptp;
  logic [7:0] job_len;
  int num_errors, n_tests, i;
  dwsc_ctrl DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wb_job_done, .wb_enable, .wb_mem_to_mem, .frame_start, .panel_active, .pipe_enable, .pipe_to_panel(ptp),
    .frame_corrupt, .smart_standby, .dma_thresh_ok, .standby_req, .mstandby, .underflow_risk(risk), .irq);
  dwsc_partner u_far (.pclk, .presetn, .wb_enable, .hold_frame(hf), .job_len, .wb_job_done, .frame_start, .panel_active);
  initial begin pclk = 0; forever #2.5 pclk = ~pclk; end
  task final_report; if (num_errors == 0 && n_tests > 0) $display("TB: PASS"); else $display("TB: FAIL"); $finish; endtask
  task cyc(input int n); repeat (n) @(posedge pclk); endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin num_errors++; final_report; end
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task s_regs;
    apb(0, 12'h858, 0); `CHK("enh_rst", 32'h0, rd)
    apb(1, 12'h858, 32'hFFFFFFFF); apb(0, 12'h858, 0); `CHK("enh_rw", 32'h1, rd)
    apb(1, 12'h858, 0); apb(0, 12'hFFC, 0); `CHK("unmapped", 1'b1, err)
  endtask
  task s_m2m;
    apb(1, 12'h010, 32'h7); apb(1, 12'h004, 32'h1); apb(1, 12'h000, 32'h1);
    cyc(12); `CHK("wb_kept", 1'b1, wb_enable)
    apb(1, 12'h000, 0); job_len <= 8'h28; apb(1, 12'h000, 32'h00080001); cyc(1);
    `CHK("m2m", 1'b1, wb_mem_to_mem)
    for (i = 0; i < 100 && wb_enable !== 1'b0; i++) @(posedge pclk);
    `CHK("autoclr", 1'b0, wb_enable)
    `CHK("pipe_on", 3'h1, pipe_enable)
    cyc(1); `CHK("irq", 1'b1, irq)
    apb(0, 12'h00C, 0); `CHK("sts", 32'h1, rd)
    cyc(1); `CHK("irq_clr", 1'b0, irq)
    hf <= 1; apb(1, 12'h004, 0);
    apb(1, 12'h000, 32'h00080001); apb(1, 12'h000, 32'h00080000);
    apb(1, 12'h008, 32'h1); apb(1, 12'h004, 32'h1);
    cyc(1); `CHK("clean", 1'b0, frame_corrupt)
    `CHK("routed", 3'h1, ptp)
  endtask
  task s_sync;
    apb(1, 12'h008, 0); apb(1, 12'h010, 32'h5); apb(1, 12'h008, 32'h1);
    cyc(1); `CHK("corrupt", 1'b1, frame_corrupt)
    `CHK("masked", 1'b0, irq)
    apb(0, 12'h00C, 0); `CHK("sts_sync", 32'h2, rd)
    hf <= 0;
    for (i = 0; i < 80 && frame_corrupt !== 1'b0; i++) @(posedge pclk);
    `CHK("frame_end", 1'b0, frame_corrupt)
  endtask
  task s_stby;
    smart_standby <= 1; standby_req <= 1; apb(1, 12'h004, 32'h3); cyc(2);
    `CHK("risk", 1'b1, risk)
    `CHK("stby", 1'b1, mstandby)
    apb(1, 12'h858, 32'h1); cyc(2); `CHK("risk_off", 1'b0, risk)
    `CHK("stby_off", 1'b0, mstandby)
    dma_thresh_ok <= 1; cyc(3); `CHK("stby_ok", 1'b1, mstandby)
    clk_en <= 0; standby_req <= 0; cyc(3); `CHK("frozen", 1'b1, mstandby)
    clk_en <= 1; cyc(2); `CHK("unfrozen", 1'b0, mstandby)
  endtask
  initial begin
    {psel, penable, pwrite, smart_standby, dma_thresh_ok, standby_req, hf, presetn, paddr, pwdata} = '0;
    clk_en = 1; job_len = 8'h04; num_errors = 0; n_tests = 0;
    cyc(2); presetn <= 1; cyc(1);
    s_regs; s_m2m; s_sync; s_stby;
    final_report;
  end
  initial begin cyc(20000); num_errors++; final_report; end
endmodule
`default_nettype wire
